// File: hw/supervisor_regs.svh
// Register offsets, field positions, reset values and timing for the sleep/wake-up supervisor
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

`define ADDR_INT_STATUS_ONE   7'h03
`define ADDR_INT_STATUS_TWO   7'h04
`define ADDR_INT_ENABLE_TWO   7'h06
`define ADDR_OP_CONTROL_ONE   7'h07
`define ADDR_CONV_CONFIG      7'h0F
`define ADDR_SENSOR_OFFSET    7'h10
`define ADDR_CONV_RESULT      7'h11
`define ADDR_TEMP_CAL         7'h12
`define ADDR_WAKE_COUNT_HIGH  7'h13
`define ADDR_WAKE_COUNT_LOW   7'h14
`define ADDR_WAKE_EXPONENT    7'h15
`define ADDR_WAKE_MANT_HIGH   7'h16
`define ADDR_WAKE_MANT_LOW    7'h17
`define ADDR_WAKE_DIVIDER     7'h18
`define ADDR_DUTY_EXT_TIME    7'h19
`define ADDR_BATT_THRESHOLD   7'h1A
`define ADDR_BATT_LEVEL       7'h1B

`define BIT_ST1_CONV_DONE     4
`define BIT_ST2_WAKE          3
`define BIT_ST2_BATT          2
`define BIT_OP_BATT_EN        6
`define BIT_OP_WAKE_EN        5
`define BIT_OP_XTAL_SEL       4
`define BIT_OP_LDC_EN         2
`define BIT_OP_AWAKE          0
`define BIT_CONV_START        7

`define RST_OP_CONTROL_ONE    8'h01
`define RST_INT_ENABLE_TWO    8'h00
`define RST_CONV_CONFIG       8'h00
`define RST_TEMP_CAL          8'h20
`define RST_BATT_THRESHOLD    8'h00
`define RST_WAKE_MANTISSA     16'h0001
`define TEMP_SENSOR_INPUT     3'h0

`define CLK_PERIOD_NS         20
`define CLK_FREQ_HZ           50000000
`define SLOW_FREQ_HZ          32768
`define SLOW_DIV              (`CLK_FREQ_HZ / `SLOW_FREQ_HZ)
`define CONV_TIME_NS          350000
`define CONV_CYCLES           ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SENSE_TIME_NS         250000
`define SENSE_CYCLES          (`SENSE_TIME_NS / `CLK_PERIOD_NS)
`define BATT_PERIOD_MS        1000
`define BATT_PERIOD_TICKS     (`SLOW_FREQ_HZ * `BATT_PERIOD_MS / 1000)
`define BATT_LOW_RUN          3'h4
`define WAKE_TICK_SHIFT       6'h05

`endif

// File: hw/supervisor_pkg.sv
// Types shared by the sleep/wake-up supervisor
package supervisor_pkg;
	typedef enum logic [3:0] {
		ST_SLEEP     = 4'h1,
		ST_AWAKE     = 4'h2,
		ST_RX_CHECK  = 4'h4,
		ST_RX_EXTEND = 4'h8
	} power_state_t;

	typedef struct packed {
		logic sclk;
		logic nsel;
		logic sdi;
	} spi_in_t;

	typedef struct packed {
		logic [2:0] input_sel;
		logic [1:0] reference;
		logic [1:0] gain;
	} conv_cfg_t;

	typedef struct packed {
		logic [1:0] range;
		logic       shift_en;
		logic [3:0] bandgap_trim;
	} temp_cfg_t;
endpackage : supervisor_pkg

// File: hw/wake_period_counter.sv
// Wake-up period counter: prescaler of 2^(5+R-D) slow ticks, then mantissa count
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.svh"
module wake_period_counter (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Control
	input  wire logic        run_i,
	input  wire logic        tick_i,
	input  wire logic [15:0] mantissa_i,
	input  wire logic [4:0]  exponent_i,
	input  wire logic [1:0]  divider_i,
	// Status
	output logic      [15:0] count_o,
	output logic             expire_o
);
	logic [31:0] pre_ff;
	logic [15:0] count_ff;
	logic        expire_ff;
	logic [5:0]  shift;
	logic [31:0] pre_limit;
	logic        pre_done;
	logic        last;

	assign shift     = {1'b0, exponent_i} + `WAKE_TICK_SHIFT - {4'h0, divider_i};
	assign pre_limit = (32'h1 << shift[4:0]) - 32'h1;
	assign pre_done  = tick_i && (pre_ff >= pre_limit);
	// A zero mantissa behaves as one
	assign last      = (count_ff + 16'h1 >= mantissa_i);
	assign count_o   = count_ff;
	assign expire_o  = expire_ff;

	always_ff @(posedge clk_i) begin
		if (!nrst_i || !run_i) begin
			pre_ff    <= 32'h0;
			count_ff  <= 16'h0;
			expire_ff <= 1'b0;
		end else begin
			expire_ff <= pre_done && last;
			if (tick_i) begin
				pre_ff <= pre_done ? 32'h0 : pre_ff + 32'h1;
			end
			if (pre_done) begin
				count_ff <= last ? 16'h0 : count_ff + 16'h1;
			end
		end
	end
endmodule : wake_period_counter
`default_nettype wire

// File: hw/sleep_wakeup_supervisor.sv
// Sleep/wake-up supervisor: SPI registers, wake timer, battery monitor, converter sequencing
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.svh"
module sleep_wakeup_supervisor
	import supervisor_pkg::*;
#(
	parameter int CONV_CYCLES       = `CONV_CYCLES,
	parameter int SENSE_CYCLES      = `SENSE_CYCLES,
	parameter int BATT_PERIOD_TICKS = `BATT_PERIOD_TICKS
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    nrst_i,
	// SPI register port
	input  wire supervisor_pkg::spi_in_t spi_i,
	output logic                         spi_sdo_o,
	output logic                         spi_sdo_oe_o,
	// Interrupt to host
	output logic                         interrupt_request_n_o,
	// Pin zero: wake output or slow crystal
	input  wire logic                    general_pin_zero_i,
	output logic                         general_pin_zero_o,
	output logic                         general_pin_zero_oe_o,
	// Analog side
	input  wire logic [4:0]              battery_code_i,
	input  wire logic [7:0]              converter_sample_i,
	input  wire logic                    test_bus_temp_i,
	output logic                         battery_sense_on_o,
	output logic                         rc_osc_enable_o,
	output logic                         temp_sensor_power_o,
	output logic                         converter_start_o,
	output supervisor_pkg::conv_cfg_t    conv_cfg_o,
	output supervisor_pkg::temp_cfg_t    temp_cfg_o,
	output logic [7:0]                   sensor_offset_o,
	// Radio sequencing
	input  wire logic                    preamble_valid_i,
	input  wire logic                    sync_valid_i,
	input  wire logic                    rx_check_done_i,
	output logic                         xtal_enable_o,
	output logic                         receiver_on_o
);
	import supervisor_pkg::*;

	localparam int IN_W = 17;

	// Input synchronisers
	logic [IN_W-1:0] sync1_ff;
	logic [IN_W-1:0] sync2_ff;
	logic            sclk_d_ff;
	logic            pin_d_ff;
	logic            sclk_s;
	logic            nsel_s;
	logic            sdi_s;
	logic            pin_s;
	logic [4:0]      batt_s;
	logic [7:0]      conv_s;

	always_ff @(posedge clk_i) begin
		sync1_ff  <= {spi_i.sclk, spi_i.nsel, spi_i.sdi, general_pin_zero_i,
			battery_code_i, converter_sample_i};
		sync2_ff  <= sync1_ff;
		sclk_d_ff <= sclk_s;
		pin_d_ff  <= pin_s;
	end

	assign {sclk_s, nsel_s, sdi_s, pin_s, batt_s, conv_s} = sync2_ff;

	// Register storage
	logic [7:0]   st1_ff;
	logic [7:0]   st2_ff;
	logic [7:0]   ien2_ff;
	logic [7:0]   op_ff;
	logic [7:0]   conv_cfg_ff;
	logic [7:0]   offset_ff;
	logic [7:0]   result_ff;
	logic [7:0]   temp_cal_ff;
	logic [4:0]   exp_ff;
	logic [15:0]  mant_ff;
	logic [1:0]   div_ff;
	logic [7:0]   ldc_ff;
	logic [4:0]   thresh_ff;
	logic [4:0]   level_ff;

	// SPI serial engine
	logic [14:0]  shift_ff;
	logic [4:0]   bit_cnt_ff;
	logic [6:0]   addr_ff;
	logic         wr_ff;
	logic [7:0]   tx_ff;
	logic         sclk_rise;
	logic         sclk_fall;
	logic [7:0]   frame_byte;
	logic         hdr_done;
	logic         wr_stb;
	logic         rd_stb;
	logic [7:0]   rd_data;
	logic [15:0]  wake_count;

	assign sclk_rise  = sclk_s && !sclk_d_ff && !nsel_s;
	assign sclk_fall  = !sclk_s && sclk_d_ff && !nsel_s;
	assign frame_byte = {shift_ff[6:0], sdi_s};
	assign hdr_done   = sclk_rise && (bit_cnt_ff == 5'h07);
	assign wr_stb     = sclk_rise && (bit_cnt_ff == 5'h0F) && wr_ff;
	assign rd_stb     = hdr_done && !frame_byte[7];

	always_ff @(posedge clk_i) begin
		if (!nrst_i || nsel_s) begin
			bit_cnt_ff <= 5'h00;
			wr_ff      <= 1'b0;
			tx_ff      <= 8'h00;
		end else begin
			if (sclk_rise) begin
				shift_ff   <= {shift_ff[13:0], sdi_s};
				bit_cnt_ff <= (bit_cnt_ff == 5'h10) ? bit_cnt_ff : bit_cnt_ff + 5'h01;
			end
			if (hdr_done) begin
				addr_ff <= frame_byte[6:0];
				wr_ff   <= frame_byte[7];
			end
			if (rd_stb) begin
				tx_ff <= rd_data;
			end else if (sclk_fall && bit_cnt_ff >= 5'h09) begin
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
		end
	end

	assign spi_sdo_o    = tx_ff[7];
	assign spi_sdo_oe_o = !nsel_s && !wr_ff && (bit_cnt_ff >= 5'h08);

	// Read decode uses the address just shifted in
	always_comb begin
		case (frame_byte[6:0])
			`ADDR_INT_STATUS_ONE:  rd_data = st1_ff;
			`ADDR_INT_STATUS_TWO:  rd_data = st2_ff;
			`ADDR_INT_ENABLE_TWO:  rd_data = ien2_ff;
			`ADDR_OP_CONTROL_ONE:  rd_data = op_ff;
			`ADDR_CONV_CONFIG:     rd_data = conv_cfg_ff;
			`ADDR_SENSOR_OFFSET:   rd_data = offset_ff;
			`ADDR_CONV_RESULT:     rd_data = result_ff;
			`ADDR_TEMP_CAL:        rd_data = temp_cal_ff;
			`ADDR_WAKE_COUNT_HIGH: rd_data = wake_count[15:8];
			`ADDR_WAKE_COUNT_LOW:  rd_data = wake_count[7:0];
			`ADDR_WAKE_EXPONENT:   rd_data = {3'h0, exp_ff};
			`ADDR_WAKE_MANT_HIGH:  rd_data = mant_ff[15:8];
			`ADDR_WAKE_MANT_LOW:   rd_data = mant_ff[7:0];
			`ADDR_WAKE_DIVIDER:    rd_data = {6'h00, div_ff};
			`ADDR_DUTY_EXT_TIME:   rd_data = ldc_ff;
			`ADDR_BATT_THRESHOLD:  rd_data = {3'h0, thresh_ff};
			`ADDR_BATT_LEVEL:      rd_data = {3'h0, level_ff};
			default:               rd_data = 8'h00;
		endcase
	end

	// Named control bits
	logic batt_en;
	logic wake_en;
	logic xtal_sel;
	logic ldc_en;
	logic awake_req;

	assign batt_en   = op_ff[`BIT_OP_BATT_EN];
	assign wake_en   = op_ff[`BIT_OP_WAKE_EN];
	assign xtal_sel  = op_ff[`BIT_OP_XTAL_SEL];
	assign ldc_en    = op_ff[`BIT_OP_LDC_EN];
	assign awake_req = op_ff[`BIT_OP_AWAKE];

	// Slow clock enable: RC divider or pin zero crystal
	logic [10:0] slow_div_ff;
	logic        rc_tick;
	logic        slow_tick;

	assign rc_tick = (slow_div_ff == 11'(`SLOW_DIV - 1));
	assign slow_tick = xtal_sel ? (pin_s && !pin_d_ff) : rc_tick;

	always_ff @(posedge clk_i) begin
		if (!nrst_i || rc_tick) begin
			slow_div_ff <= 11'h000;
		end else begin
			slow_div_ff <= slow_div_ff + 11'h001;
		end
	end

	// Power state machine
	power_state_t state_ff;
	power_state_t nxt_state;
	logic         wake_run_ff;
	logic         wake_expire;
	logic         irq_pending;
	logic         ext_done;
	logic [12:0]  ext_cnt_ff;

	assign irq_pending = |(st2_ff & ien2_ff);
	assign ext_done    = (ext_cnt_ff >= {ldc_ff, 5'h00});

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_SLEEP: begin
				if (awake_req) begin
					nxt_state = ST_AWAKE;
				end else if (wake_expire && ldc_en) begin
					nxt_state = ST_RX_CHECK;
				end else if (wake_expire && ien2_ff[`BIT_ST2_WAKE]) begin
					nxt_state = ST_AWAKE;
				end
			end
			ST_AWAKE: begin
				if (!awake_req && !irq_pending) begin
					nxt_state = ST_SLEEP;
				end
			end
			ST_RX_CHECK: begin
				if (awake_req) begin
					nxt_state = ST_AWAKE;
				end else if (rx_check_done_i) begin
					if (preamble_valid_i && sync_valid_i) begin
						nxt_state = ST_RX_EXTEND;
					end else begin
						nxt_state = ST_SLEEP;
					end
				end
			end
			ST_RX_EXTEND: begin
				if (awake_req) begin
					nxt_state = ST_AWAKE;
				end else if (ext_done) begin
					nxt_state = ST_SLEEP;
				end
			end
			default: nxt_state = ST_AWAKE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_ff    <= ST_AWAKE;
			wake_run_ff <= 1'b0;
			ext_cnt_ff  <= 13'h0000;
		end else begin
			state_ff    <= nxt_state;
			wake_run_ff <= wake_en && (wake_run_ff || nxt_state == ST_SLEEP);
			if (state_ff != ST_RX_EXTEND) begin
				ext_cnt_ff <= 13'h0000;
			end else if (slow_tick) begin
				ext_cnt_ff <= ext_cnt_ff + 13'h0001;
			end
		end
	end

	wake_period_counter u_wake (
		.clk_i      (clk_i),
		.nrst_i     (nrst_i),
		.run_i      (wake_run_ff),
		.tick_i     (slow_tick),
		.mantissa_i (mant_ff),
		.exponent_i (exp_ff),
		.divider_i  (div_ff),
		.count_o    (wake_count),
		.expire_o   (wake_expire)
	);

	// Battery monitor
	logic [15:0] batt_tick_ff;
	logic [15:0] sense_cnt_ff;
	logic        sense_ff;
	logic [2:0]  low_run_ff;
	logic        batt_low;
	logic        sense_end;
	logic        batt_set;

	assign sense_end = sense_ff && (sense_cnt_ff == 16'(SENSE_CYCLES - 1));
	// At or below threshold counts as low
	assign batt_low  = (batt_s <= thresh_ff);
	assign batt_set  = sense_end && batt_low && (low_run_ff == `BATT_LOW_RUN - 3'h1);

	always_ff @(posedge clk_i) begin
		if (!nrst_i || !batt_en) begin
			batt_tick_ff <= 16'h0000;
			sense_cnt_ff <= 16'h0000;
			sense_ff     <= 1'b0;
			low_run_ff   <= 3'h0;
		end else begin
			if (slow_tick) begin
				if (batt_tick_ff == 16'(BATT_PERIOD_TICKS - 1)) begin
					batt_tick_ff <= 16'h0000;
					sense_ff     <= 1'b1;
				end else begin
					batt_tick_ff <= batt_tick_ff + 16'h0001;
				end
			end
			if (sense_end) begin
				sense_ff     <= 1'b0;
				sense_cnt_ff <= 16'h0000;
				if (!batt_low) begin
					low_run_ff <= 3'h0;
				end else if (low_run_ff != `BATT_LOW_RUN) begin
					low_run_ff <= low_run_ff + 3'h1;
				end
			end else if (sense_ff) begin
				sense_cnt_ff <= sense_cnt_ff + 16'h0001;
			end
		end
	end

	// General converter
	logic [15:0] conv_cnt_ff;
	logic        conv_start_ff;
	logic        conv_busy;
	logic        conv_end;

	assign conv_busy = conv_cfg_ff[`BIT_CONV_START];
	assign conv_end  = conv_busy && (conv_cnt_ff == 16'(CONV_CYCLES - 1));

	always_ff @(posedge clk_i) begin
		if (!nrst_i || !conv_busy) begin
			conv_cnt_ff <= 16'h0000;
		end else begin
			conv_cnt_ff <= conv_cnt_ff + 16'h0001;
		end
	end

	// Register writes, status flags and captured results
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st1_ff        <= 8'h00;
			st2_ff        <= 8'h00;
			ien2_ff       <= `RST_INT_ENABLE_TWO;
			op_ff         <= `RST_OP_CONTROL_ONE;
			conv_cfg_ff   <= `RST_CONV_CONFIG;
			offset_ff     <= 8'h00;
			result_ff     <= 8'h00;
			temp_cal_ff   <= `RST_TEMP_CAL;
			exp_ff        <= 5'h00;
			mant_ff       <= `RST_WAKE_MANTISSA;
			div_ff        <= 2'h0;
			ldc_ff        <= 8'h00;
			thresh_ff     <= 5'(`RST_BATT_THRESHOLD);
			level_ff      <= 5'h00;
			conv_start_ff <= 1'b0;
		end else begin
			conv_start_ff <= 1'b0;
			if (wr_stb) begin
				case (addr_ff)
					`ADDR_INT_ENABLE_TWO: ien2_ff     <= frame_byte;
					`ADDR_OP_CONTROL_ONE: op_ff       <= frame_byte;
					`ADDR_CONV_CONFIG:    conv_cfg_ff <= frame_byte | (conv_cfg_ff & 8'h80);
					`ADDR_SENSOR_OFFSET:  offset_ff   <= frame_byte;
					`ADDR_TEMP_CAL:       temp_cal_ff <= frame_byte;
					`ADDR_WAKE_EXPONENT:  exp_ff      <= frame_byte[4:0];
					`ADDR_WAKE_MANT_HIGH: mant_ff[15:8] <= frame_byte;
					`ADDR_WAKE_MANT_LOW:  mant_ff[7:0]  <= frame_byte;
					`ADDR_WAKE_DIVIDER:   div_ff      <= frame_byte[1:0];
					`ADDR_DUTY_EXT_TIME:  ldc_ff      <= frame_byte;
					`ADDR_BATT_THRESHOLD: thresh_ff   <= frame_byte[4:0];
					default: ;
				endcase
				if (addr_ff == `ADDR_CONV_CONFIG && frame_byte[`BIT_CONV_START] && !conv_busy) begin
					conv_start_ff <= 1'b1;
				end
			end
			// Start bit clears at conversion end
			if (conv_end) begin
				conv_cfg_ff[`BIT_CONV_START] <= 1'b0;
				result_ff                    <= conv_s;
			end
			if (sense_end) begin
				level_ff <= batt_s;
			end
			// Read clears, a new event wins
			st1_ff <= ((rd_stb && frame_byte[6:0] == `ADDR_INT_STATUS_ONE) ? 8'h00 : st1_ff)
				| {3'h0, conv_end, 4'h0};
			st2_ff <= ((rd_stb && frame_byte[6:0] == `ADDR_INT_STATUS_TWO) ? 8'h00 : st2_ff)
				| {4'h0, wake_expire, batt_set, 2'h0};
		end
	end

	// Enabled events pull the line low
	assign interrupt_request_n_o = !irq_pending;

	// RC oscillator for monitoring and wake timing
	assign rc_osc_enable_o    = !xtal_sel && ((batt_en && state_ff == ST_SLEEP) || wake_run_ff);
	assign battery_sense_on_o = sense_ff;
	assign temp_sensor_power_o = (conv_cfg_ff[6:4] == `TEMP_SENSOR_INPUT) || test_bus_temp_i;
	assign converter_start_o   = conv_start_ff;
	assign conv_cfg_o          = conv_cfg_ff[6:0];
	// Range and shift reach the sensor
	assign temp_cfg_o.range    = temp_cal_ff[7:6];
	assign temp_cfg_o.shift_en = temp_cal_ff[5];
	assign temp_cfg_o.bandgap_trim = temp_cal_ff[4] ? temp_cal_ff[3:0] : 4'h0;
	assign sensor_offset_o     = offset_ff;
	assign xtal_enable_o       = (state_ff != ST_SLEEP);
	assign receiver_on_o       = (state_ff == ST_RX_CHECK) || (state_ff == ST_RX_EXTEND);
	assign general_pin_zero_o    = st2_ff[`BIT_ST2_WAKE];
	assign general_pin_zero_oe_o = !xtal_sel;
endmodule : sleep_wakeup_supervisor
`default_nettype wire

// File: verification/supervisor_props.sv
// Port-level assertions for the sleep/wake-up supervisor
`timescale 1ns/1ps
`default_nettype none
module supervisor_props #(
	parameter int SENSE_CYCLES = 5
) (
	// Clock and reset
	input wire logic                      clk_i,
	input wire logic                      nrst_i,
	// Observed ports
	input wire supervisor_pkg::spi_in_t   spi_i,
	input wire logic                      interrupt_request_n_o,
	input wire logic                      general_pin_zero_o,
	input wire logic                      general_pin_zero_oe_o,
	input wire logic                      test_bus_temp_i,
	input wire logic                      battery_sense_on_o,
	input wire logic                      rc_osc_enable_o,
	input wire logic                      temp_sensor_power_o,
	input wire supervisor_pkg::conv_cfg_t conv_cfg_o,
	input wire logic                      xtal_enable_o
);
	import supervisor_pkg::*;
	logic [31:0] sense_cnt_ff;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// Length of each detector power-on window
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !battery_sense_on_o)
			sense_cnt_ff <= 32'h0;
		else
			sense_cnt_ff <= sense_cnt_ff + 32'h1;
	end
	sequence s_quiet;
		spi_i.nsel [*4];
	endsequence
	sequence s_expiry;
		$rose(general_pin_zero_o) ##0 !interrupt_request_n_o;
	endsequence
	property p_temp_power;
		temp_sensor_power_o == ((conv_cfg_o.input_sel == 3'h0) | test_bus_temp_i);
	endproperty
	a_temp_power: assert property (p_temp_power) else $error("temp sensor power wrong");
	property p_sense_len; $fell(battery_sense_on_o) |-> sense_cnt_ff == SENSE_CYCLES; endproperty
	a_sense_len: assert property (p_sense_len) else $error("sense window length wrong");
	property p_irq_hold; s_quiet ##0 !interrupt_request_n_o |=> !interrupt_request_n_o; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without read");
	property p_xtal_hold; !interrupt_request_n_o && xtal_enable_o |=> xtal_enable_o; endproperty
	a_xtal_hold: assert property (p_xtal_hold) else $error("crystal off with irq pending");
	property p_wake_up; s_expiry |-> ##[0:3] xtal_enable_o; endproperty
	a_wake_up: assert property (p_wake_up) else $error("no wake-up on timer irq");
	property p_no_wake;
		$rose(general_pin_zero_o) && interrupt_request_n_o && spi_i.nsel |=> $stable(xtal_enable_o);
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("state changed without irq");
	property p_xtal_rc; !general_pin_zero_oe_o |-> !rc_osc_enable_o; endproperty
	a_xtal_rc: assert property (p_xtal_rc) else $error("rc on with crystal");
	property p_rc_sleep;
		battery_sense_on_o && !xtal_enable_o && general_pin_zero_oe_o |-> rc_osc_enable_o;
	endproperty
	a_rc_sleep: assert property (p_rc_sleep) else $error("rc off during sleep sensing");
endmodule : supervisor_props
bind sleep_wakeup_supervisor supervisor_props #(.SENSE_CYCLES(SENSE_CYCLES)) u_props (
	.clk_i(clk_i), .nrst_i(nrst_i), .spi_i(spi_i), .interrupt_request_n_o(interrupt_request_n_o),
	.general_pin_zero_o(general_pin_zero_o), .general_pin_zero_oe_o(general_pin_zero_oe_o),
	.test_bus_temp_i(test_bus_temp_i), .battery_sense_on_o(battery_sense_on_o),
	.rc_osc_enable_o(rc_osc_enable_o), .temp_sensor_power_o(temp_sensor_power_o),
	.conv_cfg_o(conv_cfg_o), .xtal_enable_o(xtal_enable_o));
`default_nettype wire

// File: verification/host_spi_model.sv
// Host microcontroller model: SPI master for the supervisor registers
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
	// Clock
	input  wire logic                   clk_i,
	// SPI to device
	output var supervisor_pkg::spi_in_t spi_o,
	input  wire logic                   sdo_i
);
	import supervisor_pkg::*;
	initial spi_o = '{sclk: 1'b0, nsel: 1'b1, sdi: 1'b0};
	// Mode 0 frame: header then data, four clocks per phase
	task automatic xfer(input logic [7:0] hdr, input logic [7:0] din, output logic [7:0] dout);
		logic [15:0] sh;
		sh = {hdr, din};
		dout = 8'h00;
		@(negedge clk_i);
		spi_o.nsel = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_o.sdi = sh[i];
			repeat (4) @(negedge clk_i);
			spi_o.sclk = 1'b1;
			if (i < 8)
				dout[i] = sdo_i;
			repeat (4) @(negedge clk_i);
			spi_o.sclk = 1'b0;
		end
		repeat (8) @(negedge clk_i);
		spi_o.nsel = 1'b1;
		spi_o.sdi = ~spi_o.sdi;
		repeat (4) @(negedge clk_i);
	endtask : xfer
endmodule : host_spi_model
`default_nettype wire

// File: verification/sleep_wakeup_supervisor_tb.sv
// Self-checking bench for the sleep/wake-up supervisor
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_supervisor_tb;
	import supervisor_pkg::*;
	localparam int CONV = 400;
	localparam int SLOW = 1525;
	logic        clk_i = 1'b0;
	logic        nrst_i;
	logic [4:0]  bat_code;
	logic [7:0]  sample;
	logic        test_bus;
	spi_in_t     spi;
	logic        sdo, irq_n, gpz_o, gpz_oe, sense_on, rc_on, temp_pwr, xtal_on;
	logic        gpz_in, rx_on;
	logic        pin_run = 1'b0, pre_ok = 1'b0, sync_ok = 1'b0, rx_done = 1'b0;
	temp_cfg_t   temp_cfg;
	int          failures = 0;
	int          comparisons = 0;
	int          senses = 0;
	int          cyc = 0;
	int          t0;
	logic [15:0] rst_tab [6] = '{16'h0701, 16'h1220, 16'h1A00, 16'h0600, 16'h0F00, 16'h7F00};
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) cyc++;
	always @(negedge sense_on) senses++;
	// Slow crystal on pin zero: one rising edge every eight clocks while running
	always @(negedge clk_i) gpz_in <= pin_run && cyc[2];
	sleep_wakeup_supervisor #(.CONV_CYCLES(CONV), .SENSE_CYCLES(5), .BATT_PERIOD_TICKS(4)) u_dut (
		.clk_i(clk_i), .nrst_i(nrst_i), .spi_i(spi), .spi_sdo_o(sdo), .spi_sdo_oe_o(),
		.interrupt_request_n_o(irq_n), .general_pin_zero_i(gpz_in), .general_pin_zero_o(gpz_o),
		.general_pin_zero_oe_o(gpz_oe), .battery_code_i(bat_code), .converter_sample_i(sample),
		.test_bus_temp_i(test_bus), .battery_sense_on_o(sense_on), .rc_osc_enable_o(rc_on),
		.temp_sensor_power_o(temp_pwr), .converter_start_o(), .conv_cfg_o(), .temp_cfg_o(temp_cfg),
		.sensor_offset_o(), .preamble_valid_i(pre_ok), .sync_valid_i(sync_ok), .rx_check_done_i(rx_done),
		.xtal_enable_o(xtal_on), .receiver_on_o(rx_on));
	host_spi_model u_host (.clk_i(clk_i), .spi_o(spi), .sdo_i(sdo));
	task automatic report_and_stop();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		u_host.xfer({1'b1, a[6:0]}, d, x);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] x;
		u_host.xfer({1'b0, a[6:0]}, 8'h00, x);
		chk(x, exp);
	endtask : rd
	// Sel 0: irq low, 1: sense count reaches goal, 2: wake pin high, 3: receiver on
	task automatic wait_until(input int sel, input int goal);
		int n;
		for (n = 0; n < 20000; n++) begin
			@(negedge clk_i);
			if (sel == 0 ? irq_n === 1'b0 : sel == 1 ? senses >= goal : sel == 2 ? gpz_o === 1'b1 : rx_on === 1'b1)
				break;
		end
		if (n >= 20000) begin
			failures++;
			$display("ERROR %0t: wait timed out", $time);
			report_and_stop();
		end
	endtask : wait_until
	initial begin
		nrst_i = 1'b0;
		bat_code = 5'h1F;
		sample = 8'h80;
		test_bus = 1'b0;
		repeat (10) @(negedge clk_i);
		nrst_i = 1'b1;
		repeat (4) @(negedge clk_i);
		senses = 0;
		foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
		chk({1'b0, temp_cfg}, 8'h10);
		chk({7'h00, temp_pwr}, 8'h01);
		wr(8'h11, 8'h55);
		rd(8'h11, 8'h00);
		wr(8'h0F, 8'h10);
		chk({7'h00, temp_pwr}, 8'h00);
		test_bus = 1'b1;
		@(negedge clk_i);
		chk({7'h00, temp_pwr}, 8'h01);
		test_bus = 1'b0;
		wr(8'h0F, 8'h00);
		wr(8'h12, 8'h20);
		wr(8'h0F, 8'h80);
		rd(8'h0F, 8'h80);
		repeat (CONV) @(negedge clk_i);
		rd(8'h0F, 8'h00);
		rd(8'h03, 8'h10);
		rd(8'h11, 8'h80);
		wr(8'h12, 8'h1A);
		chk({1'b0, temp_cfg}, 8'h0A);
		wr(8'h12, 8'h0A);
		chk({1'b0, temp_cfg}, 8'h00);
		wr(8'h1A, 8'h10);
		wr(8'h06, 8'h04);
		bat_code = 5'h10;
		wr(8'h07, 8'h40);
		wait_until(1, 3);
		chk({6'h00, rc_on, irq_n}, 8'h03);
		rd(8'h1B, 8'h10);
		wait_until(1, 4);
		repeat (4) @(negedge clk_i);
		chk({7'h00, irq_n}, 8'h00);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h04);
		chk({7'h00, irq_n}, 8'h01);
		wr(8'h07, 8'h01);
		wr(8'h17, 8'h02);
		wr(8'h18, 8'h03);
		wr(8'h06, 8'h08);
		wr(8'h07, 8'h20);
		t0 = cyc;
		chk({6'h00, xtal_on, rc_on}, 8'h01);
		wait_until(0, 0);
		chk({7'h00, (cyc - t0) inside {[7 * SLOW - 20 : 8 * SLOW + 5]}}, 8'h01);
		t0 = cyc;
		repeat (3) @(negedge clk_i);
		chk({7'h00, xtal_on}, 8'h01);
		rd(8'h04, 8'h08);
		repeat (4) @(negedge clk_i);
		chk({6'h00, xtal_on, irq_n}, 8'h01);
		// Five slow ticks into the next period the mantissa count has stepped once
		repeat (5 * SLOW) @(negedge clk_i);
		rd(8'h14, 8'h01);
		rd(8'h13, 8'h00);
		wait_until(0, 0);
		chk({7'h00, (cyc - t0) inside {[8 * SLOW - 3 : 8 * SLOW + 3]}}, 8'h01);
		rd(8'h04, 8'h08);
		wr(8'h06, 8'h00);
		wait_until(2, 0);
		repeat (2) @(negedge clk_i);
		chk({6'h00, xtal_on, irq_n}, 8'h01);
		wr(8'h07, 8'h11);
		chk({6'h00, gpz_oe, rc_on}, 8'h00);
		rd(8'h04, 8'h08);
		wr(8'h19, 8'h01);
		pin_run = 1'b1;
		wr(8'h07, 8'h34);
		// Eight crystal ticks per period: far shorter than the RC period
		repeat (100) @(negedge clk_i);
		chk({7'h00, rx_on}, 8'h01);
		repeat (4) @(negedge clk_i);
		rx_done = 1'b1;
		@(negedge clk_i);
		rx_done = 1'b0;
		chk({6'h00, xtal_on, rx_on}, 8'h00);
		wait_until(3, 0);
		repeat (4) @(negedge clk_i);
		pre_ok = 1'b1;
		sync_ok = 1'b1;
		rx_done = 1'b1;
		@(negedge clk_i);
		rx_done = 1'b0;
		pre_ok = 1'b0;
		sync_ok = 1'b0;
		t0 = cyc;
		for (int k = 0; k < 1000 && rx_on === 1'b1; k++) begin
			@(negedge clk_i);
		end
		// One extension unit is 32 slow ticks of eight clocks each
		chk({7'h00, (cyc - t0) inside {[240 : 272]}}, 8'h01);
		report_and_stop();
	end
endmodule : sleep_wakeup_supervisor_tb
`default_nettype wire
